// File: hw/power_mode_pkg.sv
// power mode controller package: register map, field positions, reset values, timing
// assumes an apb slave with 32-bit data, one aligned word per register
package power_mode_pkg;
  localparam logic [11:0] REG_REGULATOR_CONTROL = 12'h000;
  localparam logic [11:0] REG_CPU_RATE_IDLE_CONTROL = 12'h004;
  localparam logic [11:0] REG_POWER_STATUS = 12'h008;
  // regulator_control fields
  localparam int REG_LP_SEL_BIT = 1;
  localparam int REG_KEEP_SET_BIT = 0;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h01;
  // cpu_rate_idle_control fields
  localparam int IDLE_SEL_BIT = 7;
  localparam int RATE_EN_BIT = 6;
  localparam int WAKE_FULL_BIT = 5;
  localparam int ISR_EXIT_BIT = 4;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam logic [7:0] CPU_RATE_IDLE_CONTROL_RESET = 8'h00;
  // status fields
  localparam int ST_RUN_BIT = 0;
  localparam int ST_IDLE_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_SETTLE_BIT = 3;
  localparam int ST_REG_LP_BIT = 4;
  // regulator settle time after low-power sleep
  localparam int SETTLE_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_CNT_W = 8;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_SETTLE = 4'b1000
  } power_state_t;
endpackage

// File: hw/rate_divider.sv
// rate divider: one-cycle enable every 2^(code+1) clocks
// assumes code changes are rare; counter restarts on each enable
`timescale 1ns/1ps
module rate_divider import power_mode_pkg::*; #(
  parameter int CNT_W = DIV_CNT_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic [DIV_W-1:0] code,
  input wire logic run,
  // enable out
  output logic tick
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] limit;

  always_comb begin
    limit = CNT_W'((9'h002 << code) - 9'h001);
    tick = run && (count == limit);
    next_count = (!run || tick) ? '0 : count + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // rate_divider

// File: hw/power_mode_control.sv
// power mode controller: sleep/idle entry, idle wake, regulator mode, cpu rate enable
// assumes apb master on core_clk; cpu signals power-down, isr entry/exit as pulses
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module power_mode_control import power_mode_pkg::*; #(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu events
  input wire logic powerDownInstr,
  input wire logic intPending,
  input wire logic isrEnter,
  input wire logic isrExit,
  input wire logic watchdogExpire,
  input wire logic wakeEvent,
  input wire logic clkOutCfg_n,
  input wire logic sysClkPhase,
  // control outputs
  output logic cpuRun,
  output logic cpuClkEn,
  output logic progMemEn,
  output logic sysOscPeriphEn,
  output logic indepOscPeriphEn,
  output logic regulatorOn,
  output logic regulatorLowPower,
  output logic clockOutputPin,
  output logic watchdogResetBlock
);
  power_state_t state, next_state;
  logic lowPowerSel, next_lowPowerSel;
  logic idleSel, next_idleSel;
  logic rateEn, next_rateEn;
  logic wakeFull, next_wakeFull;
  logic isrExitRate, next_isrExitRate;
  logic [DIV_W-1:0] rateDiv, next_rateDiv;
  logic [15:0] settleCnt, next_settleCnt;
  logic sleptLow, next_sleptLow;
  logic [31:0] next_prdata;
  logic rateTick;
  logic wrEn, access, mapped;

  assign access = psel && penable;
  assign wrEn = access && pwrite;
  assign mapped = (paddr == REG_REGULATOR_CONTROL) || (paddr == REG_CPU_RATE_IDLE_CONTROL)
    || (paddr == REG_POWER_STATUS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  always_comb begin
    next_lowPowerSel = lowPowerSel;
    next_idleSel = idleSel;
    next_rateEn = rateEn;
    next_wakeFull = wakeFull;
    next_isrExitRate = isrExitRate;
    next_rateDiv = rateDiv;
    next_prdata = prdata;
    if (wrEn && paddr == REG_REGULATOR_CONTROL) begin
      next_lowPowerSel = pwdata[REG_LP_SEL_BIT];
    end
    if (wrEn && paddr == REG_CPU_RATE_IDLE_CONTROL) begin
      next_idleSel = pwdata[IDLE_SEL_BIT];
      next_rateEn = pwdata[RATE_EN_BIT];
      next_wakeFull = pwdata[WAKE_FULL_BIT];
      next_isrExitRate = pwdata[ISR_EXIT_BIT];
      next_rateDiv = pwdata[DIV_LSB +: DIV_W];
    end
    // hardware set/clear wins over a same-cycle software write
    if (state == ST_IDLE && intPending && wakeFull && rateEn) begin
      next_rateEn = 1'b0;
    end
    if (isrEnter && wakeFull) begin
      next_rateEn = 1'b0;
    end
    if (isrExit && isrExitRate) begin
      next_rateEn = 1'b1;
    end
    if (psel && !penable && !pwrite) begin
      next_prdata = '0;
      case (paddr)
        REG_REGULATOR_CONTROL: begin
          next_prdata[REG_LP_SEL_BIT] = lowPowerSel;
          next_prdata[REG_KEEP_SET_BIT] = 1'b1;
        end
        REG_CPU_RATE_IDLE_CONTROL: begin
          next_prdata[IDLE_SEL_BIT] = idleSel;
          next_prdata[RATE_EN_BIT] = rateEn;
          next_prdata[WAKE_FULL_BIT] = wakeFull;
          next_prdata[ISR_EXIT_BIT] = isrExitRate;
          next_prdata[DIV_LSB +: DIV_W] = rateDiv;
        end
        REG_POWER_STATUS: begin
          next_prdata[ST_RUN_BIT] = (state == ST_RUN);
          next_prdata[ST_IDLE_BIT] = (state == ST_IDLE);
          next_prdata[ST_SLEEP_BIT] = (state == ST_SLEEP);
          next_prdata[ST_SETTLE_BIT] = (state == ST_SETTLE);
          next_prdata[ST_REG_LP_BIT] = regulatorLowPower;
        end
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowPowerSel <= REGULATOR_CONTROL_RESET[REG_LP_SEL_BIT];
      idleSel <= CPU_RATE_IDLE_CONTROL_RESET[IDLE_SEL_BIT];
      rateEn <= CPU_RATE_IDLE_CONTROL_RESET[RATE_EN_BIT];
      wakeFull <= CPU_RATE_IDLE_CONTROL_RESET[WAKE_FULL_BIT];
      isrExitRate <= CPU_RATE_IDLE_CONTROL_RESET[ISR_EXIT_BIT];
      rateDiv <= CPU_RATE_IDLE_CONTROL_RESET[DIV_LSB +: DIV_W];
      prdata <= '0;
    end else begin
      lowPowerSel <= next_lowPowerSel;
      idleSel <= next_idleSel;
      rateEn <= next_rateEn;
      wakeFull <= next_wakeFull;
      isrExitRate <= next_isrExitRate;
      rateDiv <= next_rateDiv;
      prdata <= next_prdata;
    end
  end

  // power state machine
  always_comb begin
    next_state = state;
    next_settleCnt = settleCnt;
    next_sleptLow = sleptLow;
    case (state)
      ST_RUN: begin
        if (powerDownInstr) begin
          next_state = idleSel ? ST_IDLE : ST_SLEEP;
          next_sleptLow = !idleSel && lowPowerSel;
        end
      end
      ST_IDLE: begin
        // idle select untouched here so a later power-down re-enters idle
        if (intPending || watchdogExpire) begin
          next_state = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent || intPending || watchdogExpire) begin
          if (sleptLow) begin
            next_state = ST_SETTLE;
            next_settleCnt = 16'(SETTLE_COUNT - 1);
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_SETTLE: begin
        if (settleCnt == '0) begin
          next_state = ST_RUN;
          next_sleptLow = 1'b0;
        end else begin
          next_settleCnt = settleCnt - 1'b1;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      settleCnt <= '0;
      sleptLow <= 1'b0;
    end else begin
      state <= next_state;
      settleCnt <= next_settleCnt;
      sleptLow <= next_sleptLow;
    end
  end

  rate_divider #(.CNT_W(DIV_CNT_W)) cpuRateDiv (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .code(rateDiv),
    .run(rateEn && state == ST_RUN),
    .tick(rateTick)
  );

  // outputs are registered from next_state, so they are glitch free
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRun <= 1'b1;
      cpuClkEn <= 1'b1;
      progMemEn <= 1'b1;
      sysOscPeriphEn <= 1'b1;
      indepOscPeriphEn <= 1'b1;
      regulatorOn <= 1'b1;
      regulatorLowPower <= 1'b0;
      clockOutputPin <= 1'b0;
      watchdogResetBlock <= 1'b0;
    end else begin
      cpuRun <= (next_state == ST_RUN);
      cpuClkEn <= (next_state == ST_RUN) && (!next_rateEn || rateTick);
      progMemEn <= (next_state == ST_RUN);
      sysOscPeriphEn <= (next_state != ST_SLEEP);
      indepOscPeriphEn <= 1'b1;
      regulatorOn <= 1'b1;
      regulatorLowPower <= (next_state == ST_SLEEP) && next_sleptLow;
      clockOutputPin <= !clkOutCfg_n && (next_state != ST_SLEEP) && sysClkPhase;
      watchdogResetBlock <= (next_state == ST_IDLE);
    end
  end
endmodule // power_mode_control

// File: dv/power_mode_checker.sv
// checker: power mode sequencing seen at the controller ports
// assumes binding onto power_mode_control with its settle count handed on
`timescale 1ns/1ps
module power_mode_checker #(parameter int SETTLE_COUNT = 4) (
  input wire logic core_clk, rst_n, powerDownInstr, intPending, watchdogExpire,
  input wire logic clkOutCfg_n, sysClkPhase, cpuRun, progMemEn, sysOscPeriphEn,
  input wire logic indepOscPeriphEn, regulatorOn, regulatorLowPower, clockOutputPin,
  input wire logic watchdogResetBlock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_pd_halts_cpu: assert property (cpuRun && powerDownInstr |=> !cpuRun && !progMemEn)
    else $error("power-down left cpu running");
  a_idle_periph_run: assert property (watchdogResetBlock |-> sysOscPeriphEn && !progMemEn)
    else $error("idle stopped peripherals or kept memory");
  a_lp_sleep_stop: assert property (regulatorLowPower |-> !sysOscPeriphEn && !cpuRun)
    else $error("low-power regulator outside sleep");
  a_regulator_on: assert property (regulatorOn && indepOscPeriphEn)
    else $error("regulator or oscillator domain switched off");
  a_int_ends_idle: assert property (watchdogResetBlock && intPending |=> cpuRun)
    else $error("interrupt did not end idle");
  a_wdt_wakes_idle: assert property (watchdogResetBlock && watchdogExpire |=> cpuRun)
    else $error("watchdog did not wake idle");
  a_settle_after_lp: assert property (
    $fell(regulatorLowPower) |-> !cpuRun [*3] ##[1:8] cpuRun)
    else $error("no settle delay after low-power sleep");
  a_clock_output_pin_idle: assert property (watchdogResetBlock && $past(watchdogResetBlock)
    && !$past(clkOutCfg_n) |-> clockOutputPin == $past(sysClkPhase))
    else $error("clock output stopped in idle");
endmodule // power_mode_checker
bind power_mode_control power_mode_checker #(.SETTLE_COUNT(SETTLE_COUNT)) u_chk (.core_clk,
  .rst_n, .powerDownInstr, .intPending, .watchdogExpire, .clkOutCfg_n, .sysClkPhase,
  .cpuRun, .progMemEn, .sysOscPeriphEn, .indepOscPeriphEn, .regulatorOn,
  .regulatorLowPower, .clockOutputPin, .watchdogResetBlock);

// File: dv/tb.sv
// testbench: apb master, cpu event pulses, queued read checks
// assumes power_mode_control with zero-wait apb and a short settle count
`timescale 1ns/1ps
module tb import power_mode_pkg::*;;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic clkOutCfg_n = 0, sysClkPhase = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [5:0] ev = 6'h00;
  logic pready, pslverr, cpuRun, cpuClkEn, progMemEn, sysOscPeriphEn, regulatorLowPower;
  logic [31:0] expQ[$];
  int errTotal = 0, nCompared = 0, n, cyc = 0;
  integer seed = 32'h93f4;
  power_mode_control #(.SETTLE_COUNT(4)) u_power_mode_control (.core_clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .powerDownInstr(ev[0]),
    .intPending(ev[1]), .isrEnter(ev[2]), .isrExit(ev[3]), .watchdogExpire(ev[4]),
    .wakeEvent(ev[5]), .clkOutCfg_n, .sysClkPhase, .cpuRun, .cpuClkEn, .progMemEn,
    .sysOscPeriphEn, .indepOscPeriphEn(), .regulatorOn(), .regulatorLowPower,
    .clockOutputPin(), .watchdogResetBlock());
  always #5 core_clk = ~core_clk;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    nCompared++;
    if (s !== e) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // request held until pready is seen high, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // events last one cycle; outputs looked at on the following falling edge
  task automatic pulse(input logic [5:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 6'h00;
    @(negedge core_clk);
  endtask
  always @(posedge core_clk) begin
    sysClkPhase <= $random(seed);
    clkOutCfg_n <= $random(seed);
    if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0)
      cmp("prdata", expQ.pop_front(), prdata);
    // unmapped offsets answer with an error in the access phase
    if (psel && penable)
      cmp("pslverr", !(paddr inside {REG_REGULATOR_CONTROL, REG_CPU_RATE_IDLE_CONTROL,
        REG_POWER_STATUS}), pslverr);
    if (++cyc == 30000) begin
      errTotal++;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(REG_REGULATOR_CONTROL, 32'h1);
    rd(REG_CPU_RATE_IDLE_CONTROL, 32'h0);
    rd(12'h00c, 32'h0);
    rd(REG_POWER_STATUS, 32'h1);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, REG_CPU_RATE_IDLE_CONTROL, 32'h40 | k);
      repeat (2 << k) @(posedge core_clk);
      n = 0;
      repeat (8 << k) begin
        @(negedge core_clk);
        n += cpuClkEn;
      end
      cmp("cpuClkEn ticks", 32'h4, n);
    end
    apb(1'b1, REG_CPU_RATE_IDLE_CONTROL, 32'he0);
    pulse(6'h01);
    cmp("idle outputs", 3'b001, {cpuRun, progMemEn, sysOscPeriphEn});
    pulse(6'h02);
    cmp("cpuRun", 1, cpuRun);
    rd(REG_CPU_RATE_IDLE_CONTROL, 32'ha0);
    apb(1'b1, REG_CPU_RATE_IDLE_CONTROL, 32'he0);
    pulse(6'h01);
    pulse(6'h10);
    cmp("cpuRun", 1, cpuRun);
    rd(REG_CPU_RATE_IDLE_CONTROL, 32'he0);
    n = $random(seed) & 7;
    apb(1'b1, REG_CPU_RATE_IDLE_CONTROL, 32'h70 | n);
    pulse(6'h04);
    rd(REG_CPU_RATE_IDLE_CONTROL, 32'h30 | n);
    pulse(6'h08);
    rd(REG_CPU_RATE_IDLE_CONTROL, 32'h70 | n);
    apb(1'b1, REG_REGULATOR_CONTROL, 32'h3);
    apb(1'b1, REG_CPU_RATE_IDLE_CONTROL, 32'h0);
    pulse(6'h01);
    cmp("lp sleep", 2'b10, {regulatorLowPower, sysOscPeriphEn});
    pulse(6'h20);
    cmp("cpuRun settling", 0, cpuRun);
    repeat (12) @(negedge core_clk);
    cmp("cpuRun", 1, cpuRun);
    apb(1'b1, REG_REGULATOR_CONTROL, 32'h1);
    pulse(6'h01);
    cmp("regulatorLowPower", 0, regulatorLowPower);
    pulse(6'h20);
    cmp("cpuRun", 1, cpuRun);
    give_verdict;
  end
endmodule // tb
